// [src/scm_clock_ctrl.sv]
// System clock source, fast oscillator and halt-mode controller with Avalon-MM registers
// Function
// - Select code picks fast, fast divided, or sub
// - Slow mode runs CPU from slow RC sub clock
// - Fast oscillator kept in slow mode per enable
// - Halt, both keeps clear: everything stops, sleep
// - Sleep keeps slow oscillator only with watchdog
// - Halt, slow keep only: sub clock runs
// - Halt, both keeps set: both clocks run
// - Halt, fast keep only: fast clock runs
// - Switch completes after documented delay; software waits
// - Frequency code maps 8, 12, 16, 8 MHz
// - New frequency applied only once stable
// - Enabling clears stable flag until oscillator settles
// - Enable resets to one, other fields zero
//
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module scm_clock_ctrl #(
  parameter int SUB_PERIOD    = scm_pkg::SUB_PERIOD_CYC,
  parameter int SETTLE_CYCLES = scm_pkg::FAST_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // CPU and system events
  input  wire logic        halt_req,
  input  wire logic        wake_req,
  input  wire logic        watchdog_timer_en,
  // Fast oscillator handshake
  input  wire logic        fast_osc_ready,
  output logic             fast_rc_oscillator_on,
  output logic      [1:0]  fast_osc_freq_req,
  output logic      [1:0]  fast_osc_freq_applied,
  // Clock gates towards CPU and peripherals
  output logic      [2:0]  system_clock_out_src,
  output logic             system_clock_out_run,
  output logic             cpu_run,
  output logic             fast_clk_run,
  output logic             sub_clk_run,
  output logic             slow_rc_oscillator_on,
  output logic             switch_busy,
  // Interrupt
  output logic             irq
);

  typedef enum logic [1:0] {
    ST_RUN,
    ST_WAIT_OSC,
    ST_SWITCH,
    ST_HALT
  } scm_state_e;

  typedef struct packed {
    scm_state_e              state;
    logic [2:0]              src_field;
    logic                    keep_fast;
    logic                    keep_slow;
    logic [1:0]              freq_field;
    logic                    enable;
    logic                    stable;
    logic [7:0]              settle_cnt;
    logic [1:0]              freq_applied;
    logic [2:0]              src_applied;
    logic [2:0]              src_target;
    logic                    sw_start;
    logic [scm_pkg::CNT_W-1:0] sw_load;
    logic                    waitreq;
    logic [31:0]             rdata;
    logic [scm_pkg::INT_W-1:0] int_stat;
    logic [scm_pkg::INT_W-1:0] int_mask;
    logic                    irq;
    logic                    cpu_run;
    logic                    sys_run;
    logic                    fast_on;
    logic                    fast_clk;
    logic                    sub_clk;
    logic                    slow_on;
    logic                    busy;
  } scm_ctrl_s;

  scm_ctrl_s st_q;
  scm_ctrl_s st_d;

  logic tmr_done;

  // Fast oscillator period in block cycles for a frequency code
  function automatic logic [scm_pkg::CNT_W-1:0] fast_period(input logic [1:0] freq);
    unique case (freq)
      scm_pkg::FREQ_12M: fast_period = scm_pkg::CNT_W'(scm_pkg::F12_PERIOD_CYC);
      scm_pkg::FREQ_16M: fast_period = scm_pkg::CNT_W'(scm_pkg::F16_PERIOD_CYC);
      default:           fast_period = scm_pkg::CNT_W'(scm_pkg::F8_PERIOD_CYC);
    endcase
  endfunction

  // System clock period for a source code: fast shifted by the divider, or sub
  function automatic logic [scm_pkg::CNT_W-1:0] src_period(input logic [2:0] src,
                                                          input logic [1:0] freq);
    if (src == scm_pkg::SRC_SUB) begin
      src_period = scm_pkg::CNT_W'(SUB_PERIOD);
    end else begin
      src_period = fast_period(freq) << src;
    end
  endfunction

  // True when a source code draws on the fast oscillator
  function automatic logic is_fast(input logic [2:0] src);
    is_fast = (src <= scm_pkg::SRC_FAST_MAX);
  endfunction

  // Switch time, rounded down from half periods of current and target clocks
  function automatic logic [scm_pkg::CNT_W-1:0] switch_cycles(input logic [2:0] cur,
                                                             input logic [2:0] tar,
                                                             input logic [1:0] freq);
    logic [scm_pkg::CNT_W+4:0] halves;
    halves = (scm_pkg::CNT_W+5)'(src_period(cur, freq)) * (scm_pkg::CNT_W+5)'(scm_pkg::SW_CURR_FACTOR)
           + (scm_pkg::CNT_W+5)'(src_period(tar, freq)) * (scm_pkg::CNT_W+5)'(scm_pkg::SW_TAR_HALVES);
    switch_cycles = halves[scm_pkg::CNT_W:1];
  endfunction

  logic       bus_req;
  logic       bus_take;
  logic       wr_lane0;
  logic [7:0] wbyte;

  // Bus request decode; the access completes at the edge waitrequest is low
  always_comb begin
    bus_req  = avs_read | avs_write;
    bus_take = bus_req & ~st_q.waitreq;
    wr_lane0 = bus_take & avs_write & avs_byteenable[0];
    wbyte    = avs_writedata[7:0];
  end

  // Next-state logic
  always_comb begin
    st_d          = st_q;
    st_d.sw_start = 1'b0;

    // Waitrequest: one cycle of wait, then a single low cycle carrying read data
    if (bus_req && st_q.waitreq) begin
      st_d.waitreq = 1'b0;
      unique case (avs_address)
        scm_pkg::OFS_SYS_CLK_SEL: begin
          st_d.rdata = '0;
          st_d.rdata[scm_pkg::SRC_MSB:scm_pkg::SRC_LSB] = st_q.src_field;
          st_d.rdata[scm_pkg::KEEP_FAST_BIT] = st_q.keep_fast;
          st_d.rdata[scm_pkg::KEEP_SLOW_BIT] = st_q.keep_slow;
        end
        scm_pkg::OFS_FAST_OSC_CTRL: begin
          st_d.rdata = '0;
          st_d.rdata[scm_pkg::FREQ_MSB:scm_pkg::FREQ_LSB] = st_q.freq_field;
          st_d.rdata[scm_pkg::STABLE_BIT] = st_q.stable;
          st_d.rdata[scm_pkg::ENABLE_BIT] = st_q.enable;
        end
        scm_pkg::OFS_INT_STATUS: st_d.rdata = 32'(st_q.int_stat);
        scm_pkg::OFS_INT_MASK:   st_d.rdata = 32'(st_q.int_mask);
        default:                 st_d.rdata = 32'h0000_0000;
      endcase
    end else begin
      st_d.waitreq = 1'b1;
    end

    // Read of the status register clears it; events below win over the clear
    if (bus_take && avs_read && avs_address == scm_pkg::OFS_INT_STATUS) begin
      st_d.int_stat = '0;
    end

    // Register writes; the stable flag is read-only
    if (wr_lane0) begin
      unique case (avs_address)
        scm_pkg::OFS_SYS_CLK_SEL: begin
          st_d.src_field = wbyte[scm_pkg::SRC_MSB:scm_pkg::SRC_LSB];
          st_d.keep_fast = wbyte[scm_pkg::KEEP_FAST_BIT];
          st_d.keep_slow = wbyte[scm_pkg::KEEP_SLOW_BIT];
        end
        scm_pkg::OFS_FAST_OSC_CTRL: begin
          st_d.freq_field = wbyte[scm_pkg::FREQ_MSB:scm_pkg::FREQ_LSB];
          st_d.enable     = wbyte[scm_pkg::ENABLE_BIT];
          // Turning on or retuning restarts the settle wait
          if ((wbyte[scm_pkg::ENABLE_BIT] && !st_q.enable) ||
              (wbyte[scm_pkg::FREQ_MSB:scm_pkg::FREQ_LSB] != st_q.freq_field)) begin
            st_d.stable     = 1'b0;
            st_d.settle_cnt = 8'(SETTLE_CYCLES);
          end
        end
        scm_pkg::OFS_INT_MASK: st_d.int_mask = wbyte[scm_pkg::INT_W-1:0];
        default: ;
      endcase
    end

    // Mode sequencer
    unique case (st_q.state)
      ST_RUN: begin
        if (halt_req) begin
          st_d.state = ST_HALT;
        end else if (st_q.src_field != st_q.src_applied) begin
          st_d.src_target = st_q.src_field;
          // A fast target must be stable before the switch is timed
          if (is_fast(st_q.src_field) && !st_q.stable) begin
            st_d.state = ST_WAIT_OSC;
          end else begin
            st_d.state    = ST_SWITCH;
            st_d.sw_start = 1'b1;
            st_d.sw_load  = switch_cycles(st_q.src_applied, st_q.src_field, st_q.freq_applied);
          end
        end
      end
      ST_WAIT_OSC: begin
        if (st_q.stable) begin
          st_d.state    = ST_SWITCH;
          st_d.sw_start = 1'b1;
          st_d.sw_load  = switch_cycles(st_q.src_applied, st_q.src_target, st_q.freq_applied);
        end else if (!is_fast(st_q.src_field)) begin
          st_d.state = ST_RUN;
        end
      end
      ST_SWITCH: begin
        if (tmr_done) begin
          st_d.src_applied = st_q.src_target;
          st_d.state       = ST_RUN;
          st_d.int_stat[scm_pkg::INT_SWITCH_DONE] = 1'b1;
        end
      end
      ST_HALT: begin
        // Applied source is untouched, so the CPU resumes on it
        if (wake_req) begin
          st_d.state   = ST_RUN;
          st_d.int_stat[scm_pkg::INT_WAKE] = 1'b1;
        end
      end
    endcase

    // Fast oscillator: in halt per the fast keep only, else on for a fast source or target or per enable
    if (st_d.state == ST_HALT) begin
      st_d.fast_on = st_q.keep_fast;
    end else begin
      st_d.fast_on = is_fast(st_d.src_applied) | is_fast(st_d.src_field) | st_d.enable;
    end

    // Settle counter and stable flag follow the running oscillator
    if (!st_q.fast_on) begin
      st_d.stable     = 1'b0;
      st_d.settle_cnt = 8'(SETTLE_CYCLES);
    end else if (st_d.settle_cnt != 8'h00 && st_d.settle_cnt == st_q.settle_cnt) begin
      st_d.settle_cnt = st_q.settle_cnt - 8'h01;
    end else if (st_q.settle_cnt == 8'h00 && fast_osc_ready && !st_q.stable &&
                 st_d.settle_cnt == 8'h00) begin
      st_d.stable = 1'b1;
      st_d.int_stat[scm_pkg::INT_FAST_STABLE] = 1'b1;
    end

    // New frequency reaches consumers only on a stable oscillator
    if (st_q.stable) begin
      st_d.freq_applied = st_q.freq_field;
    end

    // Clock gates by mode
    st_d.cpu_run  = (st_d.state != ST_HALT);
    st_d.fast_clk = st_d.fast_on & st_d.stable;
    if (st_d.state == ST_HALT) begin
      st_d.sub_clk = st_q.keep_slow;
      st_d.slow_on = st_q.keep_slow | st_q.keep_fast | watchdog_timer_en;
      st_d.sys_run = is_fast(st_d.src_applied) ? st_q.keep_fast : st_q.keep_slow;
    end else begin
      st_d.sub_clk = 1'b1;
      st_d.slow_on = 1'b1;
      st_d.sys_run = 1'b1;
    end

    // Busy kept in the state register so the pin comes from a flop
    st_d.busy = (st_d.state == ST_SWITCH) | (st_d.state == ST_WAIT_OSC);

    // Level interrupt from masked sticky status
    st_d.irq = |(st_d.int_stat & st_d.int_mask);
  end

  // State register with reset values
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q              <= '0;
      st_q.state        <= ST_RUN;
      st_q.src_field    <= scm_pkg::RST_SRC;
      st_q.keep_fast    <= scm_pkg::RST_KEEP_FAST;
      st_q.keep_slow    <= scm_pkg::RST_KEEP_SLOW;
      st_q.freq_field   <= scm_pkg::RST_FREQ;
      st_q.enable       <= scm_pkg::RST_ENABLE;
      st_q.stable       <= scm_pkg::RST_STABLE;
      st_q.settle_cnt   <= 8'(SETTLE_CYCLES);
      st_q.freq_applied <= scm_pkg::RST_FREQ;
      st_q.src_applied  <= scm_pkg::RST_SRC;
      st_q.src_target   <= scm_pkg::RST_SRC;
      st_q.waitreq      <= 1'b1;
      st_q.int_mask     <= scm_pkg::RST_INT_MASK;
      st_q.cpu_run      <= 1'b1;
      st_q.sys_run      <= 1'b1;
      st_q.fast_on      <= 1'b1;
      st_q.sub_clk      <= 1'b1;
      st_q.slow_on      <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Switch delay timer; its count may run past thousands of cycles on the sub clock
  scm_switch_timer #(
    .CNT_W (scm_pkg::CNT_W)
  ) u_switch_timer (
    .clk   (clk),
    .srst  (srst),
    .start (st_q.sw_start),
    .load  (st_q.sw_load),
    .busy  (),
    .done  (tmr_done)
  );

  // Outputs straight from the state register
  assign avs_readdata          = st_q.rdata;
  assign avs_waitrequest       = st_q.waitreq;
  assign fast_rc_oscillator_on = st_q.fast_on;
  assign fast_osc_freq_req     = st_q.freq_field;
  assign fast_osc_freq_applied = st_q.freq_applied;
  assign system_clock_out_src  = st_q.src_applied;
  assign system_clock_out_run  = st_q.sys_run;
  assign cpu_run               = st_q.cpu_run;
  assign fast_clk_run          = st_q.fast_clk;
  assign sub_clk_run           = st_q.sub_clk;
  assign slow_rc_oscillator_on = st_q.slow_on;
  assign switch_busy           = st_q.busy;
  assign irq                   = st_q.irq;

endmodule

// [src/scm_pkg.sv]
// Package: register map, field layout, reset values and timing for the system clock mode controller
package scm_pkg;

  // Register byte offsets, one aligned 32-bit word each
  localparam logic [3:0] OFS_SYS_CLK_SEL   = 4'h0;
  localparam logic [3:0] OFS_FAST_OSC_CTRL = 4'h4;
  localparam logic [3:0] OFS_INT_STATUS    = 4'h8;
  localparam logic [3:0] OFS_INT_MASK      = 4'hc;

  // system_clock_select field positions
  localparam int SRC_LSB       = 5;
  localparam int SRC_MSB       = 7;
  localparam int KEEP_FAST_BIT = 1;
  localparam int KEEP_SLOW_BIT = 0;

  // fast_oscillator_control field positions
  localparam int FREQ_LSB   = 2;
  localparam int FREQ_MSB   = 3;
  localparam int STABLE_BIT = 1;
  localparam int ENABLE_BIT = 0;

  // Interrupt status / mask bit positions
  localparam int INT_SWITCH_DONE = 0;
  localparam int INT_FAST_STABLE = 1;
  localparam int INT_WAKE        = 2;
  localparam int INT_W           = 3;

  // Reset values
  localparam logic [2:0] RST_SRC       = 3'h0;
  localparam logic       RST_KEEP_FAST = 1'b0;
  localparam logic       RST_KEEP_SLOW = 1'b0;
  localparam logic [1:0] RST_FREQ      = 2'h0;
  localparam logic       RST_ENABLE    = 1'b1;
  localparam logic       RST_STABLE    = 1'b0;
  localparam logic [INT_W-1:0] RST_INT_MASK = 3'h0;

  // Clock source codes
  localparam logic [2:0] SRC_FAST     = 3'h0;
  localparam logic [2:0] SRC_FAST_MAX = 3'h6;
  localparam logic [2:0] SRC_SUB      = 3'h7;

  // Fast oscillator frequency codes
  localparam logic [1:0] FREQ_8M  = 2'h0;
  localparam logic [1:0] FREQ_12M = 2'h1;
  localparam logic [1:0] FREQ_16M = 2'h2;
  localparam logic [1:0] FREQ_8M_ALT = 2'h3;

  // Timing: block clock and oscillator rates
  localparam int CLK_HZ      = 40_000_000;
  localparam int SUB_HZ      = 32_000;
  localparam int FAST_8M_HZ  = 8_000_000;
  localparam int FAST_12M_HZ = 12_000_000;
  localparam int FAST_16M_HZ = 16_000_000;
  // Periods in block cycles, rounded down, never below one
  localparam int SUB_PERIOD_CYC = CLK_HZ / SUB_HZ;
  localparam int F8_PERIOD_CYC  = (CLK_HZ / FAST_8M_HZ) < 1 ? 1 : CLK_HZ / FAST_8M_HZ;
  localparam int F12_PERIOD_CYC = (CLK_HZ / FAST_12M_HZ) < 1 ? 1 : CLK_HZ / FAST_12M_HZ;
  localparam int F16_PERIOD_CYC = (CLK_HZ / FAST_16M_HZ) < 1 ? 1 : CLK_HZ / FAST_16M_HZ;
  // Switch delay: 4 system periods plus 1.5 current and 0.5 target, held in half periods
  localparam int SW_SYS_PERIODS  = 4;
  localparam int SW_CURR_HALVES  = 3;
  localparam int SW_TAR_HALVES   = 1;
  localparam int SW_CURR_FACTOR  = 2 * SW_SYS_PERIODS + SW_CURR_HALVES;
  // Minimum settle time of the fast oscillator after enable or retune, in cycles
  localparam int FAST_SETTLE_CYC = 16;

  localparam int CNT_W = 24;

endpackage

// [src/scm_switch_timer.sv]
// Down-counter that times one clock source switch
`timescale 1ns/1ps
module scm_switch_timer #(
  parameter int CNT_W = 24
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Control
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] load,
  // Status
  output logic                  busy,
  output logic                  done
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             busy;
    logic             done;
  } scm_tmr_s;

  scm_tmr_s st_q;
  scm_tmr_s st_d;

  // Count down to one, then a single done pulse
  always_comb begin
    st_d      = st_q;
    st_d.done = 1'b0;
    if (start) begin
      st_d.cnt  = (load == '0) ? CNT_W'(1) : load;
      st_d.busy = 1'b1;
    end else if (st_q.busy) begin
      if (st_q.cnt == CNT_W'(1)) begin
        st_d.busy = 1'b0;
        st_d.done = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt - CNT_W'(1);
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign busy = st_q.busy;
  assign done = st_q.done;

endmodule

// [tb/scm_checker.sv]
// Checker: bus handshake, halt gating and switch sequencing of the clock controller
`timescale 1ns/1ps
module scm_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // Register bus
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  // Events and gates
  input wire logic        halt_req,
  input wire logic        watchdog_timer_en,
  input wire logic        cpu_run,
  input wire logic        fast_rc_oscillator_on,
  input wire logic        fast_clk_run,
  input wire logic        sub_clk_run,
  input wire logic        slow_rc_oscillator_on,
  input wire logic        system_clock_out_run,
  input wire logic [2:0]  system_clock_out_src,
  input wire logic [1:0]  fast_osc_freq_applied,
  input wire logic        switch_busy
);
  typedef struct packed {
    logic kf;
    logic ks;
  } scm_keep_s;
  scm_keep_s keep_q;
  scm_keep_s keep_d;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // Shadow of the keep bits, taken only at the edge a write completes
  always_comb begin
    keep_d = keep_q;
    if (avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0]) begin
      keep_d = {avs_writedata[1], avs_writedata[0]};
    end
  end

  // Register the shadow
  always_ff @(posedge clk) begin
    if (srst) begin
      keep_q <= '0;
    end else begin
      keep_q <= keep_d;
    end
  end

  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
  a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_halt_stop: assert property (halt_req && cpu_run && !switch_busy |=> !cpu_run)
    else $error("halt did not stop the cpu");
  a_fast_gate: assert property (!cpu_run && !$past(cpu_run) |-> fast_rc_oscillator_on == keep_q.kf)
    else $error("fast oscillator gate wrong in halt");
  a_sub_gate: assert property (!cpu_run && !$past(cpu_run) |-> sub_clk_run == keep_q.ks)
    else $error("sub clock gate wrong in halt");
  a_slow_rc_gate: assert property (!cpu_run && !$past(cpu_run)
    |-> slow_rc_oscillator_on == (keep_q.ks || keep_q.kf || $past(watchdog_timer_en)))
    else $error("slow oscillator gate wrong in halt");
  a_sys_gate: assert property (!cpu_run && !$past(cpu_run)
    |-> system_clock_out_run == ((system_clock_out_src == 3'h7) ? keep_q.ks : keep_q.kf))
    else $error("system clock gate wrong in halt");
  a_src_frozen: assert property (!cpu_run && !$past(cpu_run) |-> $stable(system_clock_out_src))
    else $error("source changed while halted");
  a_src_timed: assert property ($changed(system_clock_out_src) |-> $past(switch_busy))
    else $error("source changed without a timed switch");
  a_stable_off: assert property (!fast_rc_oscillator_on |=> !fast_clk_run)
    else $error("fast clock reported running while oscillator off");
  a_freq_stable: assert property ($changed(fast_osc_freq_applied) |-> ##[0:2] fast_clk_run)
    else $error("frequency applied without stable oscillator");
endmodule

bind scm_clock_ctrl scm_checker scm_checker_inst (.clk, .srst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_waitrequest, .halt_req, .watchdog_timer_en, .cpu_run,
  .fast_rc_oscillator_on, .fast_clk_run, .sub_clk_run, .slow_rc_oscillator_on, .system_clock_out_run,
  .system_clock_out_src, .fast_osc_freq_applied, .switch_busy);

// [tb/scm_osc_model.sv]
// Fast oscillator model: ready follows enable after a start-up delay
`timescale 1ns/1ps
module scm_osc_model #(
  parameter int START_CYC = 6
) (
  // Clock
  input  wire logic clk,
  // Oscillator control and status
  input  wire logic osc_on,
  output logic      osc_ready
);
  int cnt = 0;

  // Needs a run of enabled cycles; drops at once when switched off
  always_ff @(posedge clk) begin
    if (!osc_on) begin
      cnt <= 0;
    end else if (cnt < START_CYC) begin
      cnt <= cnt + 1;
    end
  end

  assign osc_ready = osc_on && (cnt >= START_CYC);
endmodule

// [tb/tb_top.sv]
// Testbench: registers, source switching, frequency retune and halt modes
`timescale 1ns/1ps
module tb_top;
  logic        clk, srst, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        halt_req, wake_req, watchdog_timer_en, fast_osc_ready;
  logic        fast_rc_oscillator_on, fast_clk_run, sub_clk_run, slow_rc_oscillator_on;
  logic        system_clock_out_run, cpu_run, switch_busy, irq;
  logic [1:0]  fast_osc_freq_req, fast_osc_freq_applied;
  logic [2:0]  system_clock_out_src;
  int          failures, check_count, cycles;

  // Short sub period and settle time keep the run brief
  scm_clock_ctrl #(.SUB_PERIOD(20), .SETTLE_CYCLES(4)) scm_clock_ctrl_inst (.clk, .srst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .halt_req,
    .wake_req, .watchdog_timer_en, .fast_osc_ready, .fast_rc_oscillator_on, .fast_osc_freq_req,
    .fast_osc_freq_applied, .system_clock_out_src, .system_clock_out_run, .cpu_run, .fast_clk_run,
    .sub_clk_run, .slow_rc_oscillator_on, .switch_busy, .irq);
  scm_osc_model scm_osc_model_inst (.clk(clk), .osc_on(fast_rc_oscillator_on), .osc_ready(fast_osc_ready));

  // Clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      failures++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  // One bus access; held until waitrequest is seen low, then one idle edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
    chk(avs_waitrequest === 1'b1, "waitrequest low past one cycle");
  endtask

  task automatic t_reset();
    bus(1'b0, scm_pkg::OFS_SYS_CLK_SEL, 32'h0);
    chk(rd === 32'h0, "select reset value");
    bus(1'b0, scm_pkg::OFS_FAST_OSC_CTRL, 32'h0);
    chk((rd & ~32'h2) === 32'h1, "fast control reset value");
    bus(1'b1, 4'h2, 32'hff);
    bus(1'b0, 4'h2, 32'h0);
    chk(rd === 32'h0, "unmapped read");
    $display("reset test done");
  endtask

  // Step through every source code, timing each switch
  task automatic t_switch();
    int n;
    int tcur;
    int ttar;
    for (int i = 1; i < 9; i++) begin
      tcur = (i == 8) ? 20 : (5 << (i - 1));
      ttar = (i == 7) ? 20 : (5 << (i % 8));
      bus(1'b1, scm_pkg::OFS_SYS_CLK_SEL, 32'((i % 8) << 5));
      n = 0;
      while (system_clock_out_src !== 3'(i % 8) && n < 4000) begin
        @(posedge clk);
        n++;
      end
      chk(system_clock_out_src === 3'(i % 8), "source not switched");
      chk(n + 2 >= 4 * tcur, "switch faster than four periods");
      chk(n <= (11 * tcur + ttar) / 2 + 12, "switch slower than allowed");
      if (i == 7) begin
        chk(sub_clk_run === 1'b1 && fast_rc_oscillator_on === 1'b1, "slow mode clocks");
        bus(1'b1, scm_pkg::OFS_FAST_OSC_CTRL, 32'h0);
        repeat (3) @(posedge clk);
        chk(fast_rc_oscillator_on === 1'b0, "fast osc kept despite enable off");
        bus(1'b1, scm_pkg::OFS_FAST_OSC_CTRL, 32'h1);
      end
    end
    bus(1'b0, scm_pkg::OFS_INT_STATUS, 32'h0);
    chk(rd[0] === 1'b1, "switch done status");
    bus(1'b0, scm_pkg::OFS_INT_STATUS, 32'h0);
    chk(rd[0] === 1'b0, "status not cleared by read");
    $display("switch test done");
  endtask

  // Retune through all codes; stable drops and the new code waits for it
  task automatic t_freq();
    int n;
    logic [1:0] f;
    for (int i = 1; i < 5; i++) begin
      f = 2'(i % 4);
      bus(1'b1, scm_pkg::OFS_FAST_OSC_CTRL, {28'h0, f, 2'h1});
      bus(1'b0, scm_pkg::OFS_FAST_OSC_CTRL, 32'h0);
      chk(rd[1] === 1'b0, "stable not cleared on retune");
      n = 0;
      while (rd[1] !== 1'b1 && n < 20) begin
        bus(1'b0, scm_pkg::OFS_FAST_OSC_CTRL, 32'h0);
        n++;
      end
      chk(rd[1] === 1'b1, "stable never set");
      chk(fast_osc_freq_req === f, "frequency code");
      chk(fast_osc_freq_applied === f, "frequency not applied");
    end
    $display("frequency test done");
  endtask

  // All four keep combinations, plus sleep with watchdog and a masked wake
  task automatic t_halt();
    logic [1:0] kb;
    logic       wdt;
    for (int i = 0; i < 5; i++) begin
      kb  = 2'(i);
      wdt = (i == 4);
      bus(1'b1, scm_pkg::OFS_SYS_CLK_SEL, {30'h0, kb});
      bus(1'b1, scm_pkg::OFS_INT_MASK, (i == 4) ? 32'h0 : 32'h4);
      bus(1'b0, scm_pkg::OFS_INT_STATUS, 32'h0);
      watchdog_timer_en <= wdt;
      halt_req          <= 1'b1;
      @(posedge clk);
      halt_req <= 1'b0;
      repeat (3) @(posedge clk);
      chk(cpu_run === 1'b0, "cpu still running in halt");
      chk(fast_rc_oscillator_on === kb[1], "fast oscillator gate");
      chk(sub_clk_run === kb[0], "sub clock gate");
      chk(slow_rc_oscillator_on === (kb != 2'h0 || wdt), "slow oscillator gate");
      chk(system_clock_out_run === kb[1], "system clock gate");
      wake_req <= 1'b1;
      @(posedge clk);
      wake_req <= 1'b0;
      repeat (3) @(posedge clk);
      chk(cpu_run === 1'b1 && system_clock_out_src === 3'h0, "wake source");
      chk(irq === (i != 4), "wake interrupt");
      bus(1'b0, scm_pkg::OFS_INT_STATUS, 32'h0);
      chk(rd[2] === 1'b1, "wake status");
      repeat (2) @(posedge clk);
      chk(irq === 1'b0, "interrupt not cleared");
    end
    $display("halt test done");
  endtask

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures++;
      $display("Error at %0t: timeout", $time);
      summarize();
    end
  end

  // Main sequence
  initial begin
    {avs_read, avs_write, halt_req, wake_req, watchdog_timer_en} = '0;
    avs_address    = 4'h0;
    avs_byteenable = 4'hf;
    avs_writedata  = 32'h0;
    failures       = 0;
    check_count    = 0;
    cycles         = 0;
    srst           = 1'b1;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_switch();
    t_freq();
    t_halt();
    summarize();
  end
endmodule
